/* File: src/adc_ctrl_defs.vh */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_GLOBAL_CONFIG 12'h000
`define OFS_TRIGGER_CTRL  12'h004
`define OFS_START_STROBE  12'h008
`define OFS_DELAY_SETUP   12'h00c
`define OFS_RESULT_HEAD   12'h010
`define OFS_STATUS        12'h014

// ****************************************
// Field positions
// ****************************************
`define GC_ENABLE     0
`define GC_DIFF       1
`define GC_TOUCH_LSB  2
`define GC_TOUCH_MSB  4
`define TC_POL        0
`define TC_EXT        1
`define TC_AUTO       2
`define DS_SKEW_MSB   4
`define DS_DLY_LSB    5
`define DS_DLY_MSB    13
`define DS_DIV_LSB    14
`define DS_DIV_MSB    15
`define RS_SIGN       12
`define RS_PEN        13
`define RS_OFLW       14
`define RS_DONE       15

// ****************************************
// Values and timing
// ****************************************
`define RESET_VALUE     16'h0000
`define TOUCH_PEN_DET   3'h5
`define SKEW_MAX        5'h14
`define SYS_CLK_MHZ     8'd100
`define ADC_CLK_MHZ     8'd12

`endif

/* File: src/adc_trigger_delay_result_fifo.v */
`default_nettype none
`include "adc_ctrl_defs.vh"

module adc_trigger_delay_result_fifo #(
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        trigger_input_pin,
  input  wire        pen_detect,
  input  wire        conv_done,
  input  wire [11:0] conv_value,
  input  wire        conv_sign,
  output reg         conv_start,
  output reg         conv_diff,
  output reg  [4:0]  clock_skew_delay,
  output reg  [2:0]  touch_driver_config,
  output reg         converter_enable,
  output reg         converter_wakeup_out
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_CONV  = 2'h2;
  // ST_CONV is left only when the core reports done or the enable drops

  function sel_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  // Unknown offsets answer with an error and read as zero
  function reg_known;
    input [11:0] a;
    begin
      reg_known = sel_hit(a, `OFS_GLOBAL_CONFIG) | sel_hit(a, `OFS_TRIGGER_CTRL)
                | sel_hit(a, `OFS_START_STROBE) | sel_hit(a, `OFS_DELAY_SETUP)
                | sel_hit(a, `OFS_RESULT_HEAD) | sel_hit(a, `OFS_STATUS);
    end
  endfunction

  // Pointer step wraps at DEPTH, so a depth that is not a power of two works
  function [AW-1:0] ptr_next;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_next = {AW{1'b0}};
      else
        ptr_next = p + 1'b1;
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  reg  [15:0]   trig_ctrl;
  reg  [15:0]   delay_setup;
  reg  [1:0]    state;
  reg           primed;
  reg  [8:0]    delay_left;
  reg  [6:0]    frac_acc;
  reg  [1:0]    div_cnt;
  reg           trg_s1;
  reg           trg_s2;
  reg           trg_s3;
  reg           pen_s1;
  reg           pen_s2;
  reg  [12:0]   mem [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   count;
  reg           done;
  reg           overflow;

  // ****************************************
  // Bus decode
  // ****************************************
  wire acc    = psel & penable & ~pready;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  // Writes and pops act on the first access edge, the same edge that raises pready
  wire known  = reg_known(paddr);
  // Trigger, delay and start writes are locked while the converter is off; global config stays writable
  wire wr_ok  = wr & converter_enable;
  wire start_wr = wr_ok & sel_hit(paddr, `OFS_START_STROBE);
  wire wr_gc  = wr & sel_hit(paddr, `OFS_GLOBAL_CONFIG);
  wire wr_tc  = wr_ok & sel_hit(paddr, `OFS_TRIGGER_CTRL);
  wire wr_ds  = wr_ok & sel_hit(paddr, `OFS_DELAY_SETUP);
  wire rd_res = rd & sel_hit(paddr, `OFS_RESULT_HEAD);
  wire pop    = rd_res & done;

  // ****************************************
  // Trigger qualification
  // ****************************************
  // Edge detect only looks at the second and third stages
  wire rise   = trg_s2 & ~trg_s3;
  wire fall   = ~trg_s2 & trg_s3;
  wire edge_q = trig_ctrl[`TC_POL] ? fall : rise;
  wire external_trigger_select    = trig_ctrl[`TC_EXT];
  wire autom  = trig_ctrl[`TC_AUTO] & external_trigger_select;
  // Priming only matters on the pin path without auto mode
  wire trig_ev = ~external_trigger_select ? start_wr
               : autom ? edge_q
               : (primed & edge_q);

  // ****************************************
  // Delay timebase
  // ****************************************
  // 12 MHz tick from the 100 MHz clock by a fractional accumulator;
  // jitter of one system clock is accepted to stay single-domain
  wire [7:0] acc_sum = {1'b0, frac_acc} + `ADC_CLK_MHZ;
  wire adc_tick = (acc_sum >= `SYS_CLK_MHZ);
  wire [7:0] acc_wrap = acc_sum - `SYS_CLK_MHZ;
  wire [1:0] div_n = delay_setup[`DS_DIV_MSB:`DS_DIV_LSB];
  // Divider phase runs free, so the first delay period may be partial
  wire base_tick = adc_tick & (div_cnt == div_n);

  always @(posedge clk)
  begin
    if (rst)
    begin
      frac_acc <= 7'h00;
      div_cnt  <= 2'h0;
    end
    else
    begin
      if (adc_tick)
        frac_acc <= acc_wrap[6:0];
      else
        frac_acc <= acc_sum[6:0];
      if (adc_tick)
        div_cnt <= (div_cnt >= div_n) ? 2'h0 : div_cnt + 2'h1;
    end
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_s3 <= 1'b0;
      pen_s1 <= 1'b0;
      pen_s2 <= 1'b0;
    end
    else
    begin
      trg_s1 <= trigger_input_pin;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
      // Pen detector is asynchronous as well, so it gets two stages
      pen_s1 <= pen_detect;
      pen_s2 <= pen_s1;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      primed     <= 1'b0;
      delay_left <= 9'h000;
      conv_start <= 1'b0;
    end
    else if (!converter_enable)
    begin
      state      <= ST_IDLE;
      primed     <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      // Edges that come outside idle are lost: one conversion at a time
      case (state)
        ST_IDLE:
        begin
          if (trig_ev)
          begin
            state      <= ST_DELAY;
            delay_left <= delay_setup[`DS_DLY_MSB:`DS_DLY_LSB];
          end
        end
        ST_DELAY:
        begin
          // A field of zero starts the conversion on the next clock
          if (delay_left == 9'h000)
          begin
            state      <= ST_CONV;
            conv_start <= 1'b1;
          end
          else if (base_tick)
            delay_left <= delay_left - 9'h001;
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            state  <= ST_IDLE;
            primed <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
      // Placed after the case so a write that meets the end of a
      // conversion still primes the next one
      if (start_wr && external_trigger_select && !autom)
        primed <= 1'b1;
    end
  end

  // ****************************************
  // Result FIFO
  // ****************************************
  wire push = conv_done & (state == ST_CONV) & converter_enable;
  wire full = (count == DEPTH);
  // A push that meets a pop while full still fits, so it is no overflow
  wire do_push = push & (~full | pop);
  wire [12:0] head = mem[rd_ptr];

  // Sign is masked at push, so a later mode change leaves queued data alone
  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= {conv_sign & conv_diff, conv_value};
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      done     <= 1'b0;
      overflow <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= ptr_next(wr_ptr);
      if (pop)
        rd_ptr <= ptr_next(rd_ptr);
      if (do_push && !pop)
        count <= count + 1'b1;
      else if (pop && !do_push)
        count <= count - 1'b1;
      // A read drops done for one clock even with entries queued
      done <= (count != 0) & ~pop;
      if (push && full && !pop)
        overflow <= 1'b1;
      else if (rd_res)
        overflow <= 1'b0;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      converter_enable    <= 1'b0;
      conv_diff           <= 1'b0;
      touch_driver_config <= 3'h0;
      trig_ctrl           <= `RESET_VALUE;
      delay_setup         <= `RESET_VALUE;
    end
    else
    begin
      if (wr_gc)
      begin
        converter_enable    <= pwdata[`GC_ENABLE];
        conv_diff           <= pwdata[`GC_DIFF];
        touch_driver_config <= pwdata[`GC_TOUCH_MSB:`GC_TOUCH_LSB];
      end
      // Unused control bits are kept at zero so they read back as zero
      if (wr_tc)
        trig_ctrl <= {13'h0000, pwdata[2:0]};
      if (wr_ds)
        delay_setup <= pwdata[15:0];
    end
  end

  // ****************************************
  // Skew output
  // ****************************************
  // Values above the limit act as the limit, so the output never exceeds it
  always @(posedge clk)
  begin
    if (rst)
      clock_skew_delay <= 5'h00;
    else if (delay_setup[`DS_SKEW_MSB:0] > `SKEW_MAX)
      clock_skew_delay <= `SKEW_MAX;
    else
      clock_skew_delay <= delay_setup[`DS_SKEW_MSB:0];
  end

  // ****************************************
  // Read path and pen status
  // ****************************************
  wire pen_on  = (touch_driver_config == `TOUCH_PEN_DET);
  // Pen bit bypasses the FIFO and reads the live detector
  wire pen_bit = pen_on & ~pen_s2;
  reg  [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h00000000;
    if (sel_hit(paddr, `OFS_GLOBAL_CONFIG))
      next_rdata[4:0] = {touch_driver_config, conv_diff, converter_enable};
    else if (sel_hit(paddr, `OFS_TRIGGER_CTRL))
      next_rdata[15:0] = trig_ctrl;
    else if (sel_hit(paddr, `OFS_DELAY_SETUP))
      next_rdata[15:0] = delay_setup;
    else if (sel_hit(paddr, `OFS_RESULT_HEAD))
    begin
      next_rdata[12:0] = done ? head : 13'h0000;
      next_rdata[`RS_PEN] = pen_bit;
      next_rdata[`RS_OFLW] = overflow;
      next_rdata[`RS_DONE] = done;
    end
    else if (sel_hit(paddr, `OFS_STATUS))
      // Triggered stays high through the conversion itself
      next_rdata[2:0] = {state == ST_CONV, state != ST_IDLE, primed};
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      converter_wakeup_out <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~known;
      // Read data is taken before the pop on the same edge moves the head
      if (rd)
        prdata <= next_rdata;
      // Wake-up follows the synchronised pen signal or done in pen-detect mode, not the raw pin
      converter_wakeup_out <= pen_on & (pen_s2 | done);
    end
  end

endmodule // adc_trigger_delay_result_fifo
`default_nettype wire

/* File: sim/adc_fifo_props.sv */
`default_nettype none
`include "adc_ctrl_defs.vh"
// ****
// Port checks
// ****
module adc_fifo_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_start,
  input wire logic [4:0]  clock_skew_delay,
  input wire logic [2:0]  touch_driver_config,
  input wire logic        converter_enable,
  input wire logic        converter_wakeup_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  a_unmapped_err: assert property (pslverr ==
    (pready && (paddr > `OFS_STATUS || paddr[1:0] != 2'h0)))
    else $error("bad pslverr");
  a_start_pulse: assert property (conv_start |=> !conv_start [*2])
    else $error("start too long");
  a_skew_clamp: assert property (clock_skew_delay <= `SKEW_MAX)
    else $error("skew over limit");
  a_wake_gate: assert property ((touch_driver_config != `TOUCH_PEN_DET) &&
    ($past(touch_driver_config) != `TOUCH_PEN_DET) |-> !converter_wakeup_out)
    else $error("wakeup outside detect");
  a_off_idle: assert property (!converter_enable && !$past(converter_enable)
    |-> !conv_start)
    else $error("start while off");
  a_empty_zero: assert property (pready && !pwrite &&
    paddr == `OFS_RESULT_HEAD && !prdata[`RS_DONE] |-> prdata[12:0] == 13'h0000)
    else $error("value without done");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule // adc_fifo_props
bind adc_trigger_delay_result_fifo adc_fifo_props props (.*);
`default_nettype wire

/* File: sim/conv_core_model.sv */
`default_nettype none
// ****
// Converter core stand-in
// ****
module conv_core_model (
  input  wire logic        clk,
  input  wire logic        conv_start,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] next_value,
  input  wire logic        next_sign,
  output var  logic        conv_done,
  output var  logic [11:0] conv_value,
  output var  logic        conv_sign
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0]  cnt = 5'h00;
  logic [12:0] held = 13'h0000;
  initial {conv_done, conv_sign, conv_value} = 14'h0000;
  always @(posedge clk)
  begin
    conv_done <= 1'b0;
    // Stale result must never look valid, so the bus flips on every clock except the done one
    {conv_sign, conv_value} <= ~{conv_sign, conv_value};
    if (conv_start)
    begin
      held <= {next_sign, next_value};
      cnt <= {1'b0, lat} + 5'h01;
    end
    else if (cnt == 5'h01)
    begin
      conv_done <= 1'b1;
      {conv_sign, conv_value} <= held;
      cnt <= 5'h00;
    end
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
endmodule // conv_core_model
`default_nettype wire

/* File: sim/adc_trigger_delay_result_fifo_tb.sv */
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_trigger_delay_result_fifo_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, dif, ovf;
  logic        trigger_input_pin, pen_detect, conv_done, conv_sign, conv_start;
  logic        next_sign, converter_enable, converter_wakeup_out, conv_diff;
  logic [11:0] paddr, conv_value, next_value;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  clock_skew_delay;
  logic [2:0]  touch_driver_config;
  logic [3:0]  lat;
  logic [12:0] q [$];
  int          err_count = 0, n_compared = 0, cyc = 0, n, d, v, k, e;
  adc_trigger_delay_result_fifo dut (.*);
  conv_core_model core (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // Bench tasks
  // ****
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (!pready && ++t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(t < 50, 1);
  endtask
  task automatic watch(input logic x);
    n = 0;
    while (n < 900 && !conv_start)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 900, x);
    repeat (40) @(posedge clk);
  endtask
  task automatic rdq(input logic pen = 1'b0);
    logic [31:0] ex;
    ex = {18'h00000, pen, 13'h0000};
    if (q.size() > 0)
      ex = {16'h0000, 1'b1, ovf, pen, q.pop_front()};
    ovf = 1'b0;
    apb(1'b0, `OFS_RESULT_HEAD, 32'h0);
    chk(rd, ex);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (conv_done)
      {next_sign, next_value, lat} <= 17'($urandom);
    if (conv_start && q.size() < 4)
      q.push_back({next_sign & dif, next_value});
    else if (conv_start)
      ovf = 1'b1;
    if (cyc > 60000)
    begin
      err_count++;
      print_verdict();
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(37));
    {psel, penable, pwrite, paddr, pwdata, trigger_input_pin, pen_detect} = '0;
    {dif, ovf} = 2'b00;
    {next_sign, next_value, lat} = 17'($urandom);
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1, `OFS_START_STROBE, 0);
    watch(0);
    apb(1, `OFS_GLOBAL_CONFIG, 32'h1);
    repeat (5)
    begin
      apb(1, `OFS_START_STROBE, $urandom);
      watch(1);
    end
    repeat (5) rdq();
    apb(1, `OFS_GLOBAL_CONFIG, 32'h3);
    dif = 1'b1;
    chk(conv_diff, 1);
    apb(1, `OFS_START_STROBE, 0);
    watch(1);
    rdq();
    apb(0, `OFS_START_STROBE, 0);
    chk(rd, 0);
    for (int p = 0; p < 2; p++)
    begin
      apb(1, `OFS_TRIGGER_CTRL, 32'h6 | p);
      trigger_input_pin <= 1'b1;
      watch(!p[0]);
      trigger_input_pin <= 1'b0;
      watch(p[0]);
      rdq();
    end
    apb(1, `OFS_TRIGGER_CTRL, 32'h2);
    trigger_input_pin <= 1'b1;
    watch(0);
    trigger_input_pin <= 1'b0;
    apb(1, `OFS_START_STROBE, 0);
    apb(0, `OFS_STATUS, 0);
    chk(rd, 32'h1);
    trigger_input_pin <= 1'b1;
    watch(1);
    trigger_input_pin <= 1'b0;
    watch(0);
    trigger_input_pin <= 1'b1;
    watch(0);
    rdq();
    apb(1, `OFS_TRIGGER_CTRL, 32'h4);
    trigger_input_pin <= 1'b0;
    watch(0);
    trigger_input_pin <= 1'b1;
    watch(0);
    repeat (3)
    begin
      d = $urandom_range(20, 10);
      v = $urandom_range(3, 0);
      k = $urandom_range(31, 16);
      apb(1, `OFS_DELAY_SETUP, {v[1:0], d[8:0], k[4:0]});
      @(posedge clk);
      chk(clock_skew_delay, k > 20 ? 20 : k);
      apb(1, `OFS_START_STROBE, 0);
      watch(1);
      e = d * (v + 1) * 100 / 12;
      chk(n + (v + 1) * 9 + 3 > e && n < e + 12, 1);
      rdq();
    end
    apb(1, `OFS_DELAY_SETUP, {2'b01, 9'd60, 5'd0});
    apb(1, `OFS_START_STROBE, 0);
    apb(1, `OFS_GLOBAL_CONFIG, 32'h0);
    apb(1, `OFS_GLOBAL_CONFIG, 32'h1);
    watch(0);
    apb(0, 12'h018, 0);
    chk({31'h0, err}, 1);
    chk(rd, 0);
    apb(1, `OFS_GLOBAL_CONFIG, 32'h15);
    repeat (5) @(posedge clk);
    chk(touch_driver_config, 3'h5);
    chk(converter_wakeup_out, 0);
    rdq(1'b1);
    chk(rd, 32'h2000);
    pen_detect <= 1'b1;
    repeat (5) @(posedge clk);
    chk(converter_wakeup_out, 1);
    rdq();
    chk(rd, 0);
    print_verdict();
  end
endmodule // adc_trigger_delay_result_fifo_tb
`default_nettype wire
